// File: include/gpp_cfg.svh
// Register offsets, reset values and register count for the port block.
`ifndef GPP_CFG_SVH
`define GPP_CFG_SVH
`define GPP_ADDR_PORT_ONE_DATA 8'h90
`define GPP_ADDR_PORT_TWO_DATA 8'hA0
`define GPP_ADDR_PORT_ZERO_MDOUT 8'hA4
`define GPP_ADDR_PORT_ONE_MDOUT 8'hA5
`define GPP_ADDR_PORT_TWO_MDOUT 8'hA6
`define GPP_ADDR_PORT_ZERO_SKIP 8'hD4
`define GPP_ADDR_PORT_ZERO_MDIN 8'hF1
`define GPP_ADDR_PORT_ONE_MDIN 8'hF2
`define GPP_ADDR_PORT_TWO_MDIN 8'hF3
`define GPP_RST_DATA 8'hFF
`define GPP_RST_MDOUT 8'h00
`define GPP_RST_MDIN 8'hFF
`define GPP_RST_SKIP 8'h00
`define GPP_NUM_REGS 9
`endif

// File: include/gpp_pkg.sv
// Types shared by the port block files.
package gpp_pkg;
  typedef logic [7:0] gpp_byte_t;
  typedef logic [3:0] gpp_idx_t;
endpackage

// File: rtl/gpp_regfile.sv
// Small register store for the port configuration bytes, read data registered.
`timescale 1ns/100ps
`include "gpp_cfg.svh"
module gpp_regfile (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire gpp_pkg::gpp_idx_t wr_idx,
  input wire gpp_pkg::gpp_byte_t wr_data,
  input wire gpp_pkg::gpp_idx_t rd_idx,
  output gpp_pkg::gpp_byte_t rd_data,
  output gpp_pkg::gpp_byte_t regs_flat [`GPP_NUM_REGS]
);
  // Storage and its next value.
  gpp_pkg::gpp_byte_t mem_q [`GPP_NUM_REGS];
  gpp_pkg::gpp_byte_t mem_d [`GPP_NUM_REGS];
  gpp_pkg::gpp_byte_t rd_q;
  gpp_pkg::gpp_byte_t rd_d;

  // Reset value for each slot: data latches high, input modes high (digital), rest low.
  function automatic gpp_pkg::gpp_byte_t rst_val(input int idx);
    if (idx < 2) begin
      rst_val = `GPP_RST_DATA;
    end else if (idx < 5) begin
      rst_val = `GPP_RST_MDOUT;
    end else if (idx == 5) begin
      rst_val = `GPP_RST_SKIP;
    end else begin
      rst_val = `GPP_RST_MDIN;
    end
  endfunction

  // Next values: a write replaces one slot, others hold.
  always_comb begin
    for (int i = 0; i < `GPP_NUM_REGS; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (wr_en && (int'(wr_idx) < `GPP_NUM_REGS)) begin
      mem_d[wr_idx] = wr_data;
    end
    rd_d = (int'(rd_idx) < `GPP_NUM_REGS) ? mem_q[rd_idx] : 8'h00;
  end

  // Registers only.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < `GPP_NUM_REGS; i++) begin
        mem_q[i] <= rst_val(i);
      end
      rd_q <= 8'h00;
    end else begin
      mem_q <= mem_d;
      rd_q <= rd_d;
    end
  end

  assign rd_data = rd_q;
  assign regs_flat = mem_q;
endmodule

// File: rtl/gpp_port_top.sv
// General-purpose port data latches, pin readback and drive-mode control.
`timescale 1ns/100ps
`include "gpp_cfg.svh"
module gpp_port_top (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  input wire logic crossbar_global_enable,
  input wire logic [7:0] port_one_pin_in,
  input wire logic [7:0] port_two_pin_in,
  output logic [7:0] port_one_pin_out,
  output logic [7:0] port_one_pin_oe,
  output logic [7:0] port_two_pin_out,
  output logic [7:0] port_two_pin_oe,
  output logic [7:0] port_zero_crossbar_bypass,
  output logic [7:0] port_zero_analog_select,
  output logic [7:0] port_zero_output_drive_mode
);
  // Slot numbers inside the register store.
  localparam gpp_pkg::gpp_idx_t IDX_P1 = 4'h0;
  localparam gpp_pkg::gpp_idx_t IDX_P2 = 4'h1;
  localparam gpp_pkg::gpp_idx_t IDX_M0 = 4'h2;
  localparam gpp_pkg::gpp_idx_t IDX_M1 = 4'h3;
  localparam gpp_pkg::gpp_idx_t IDX_M2 = 4'h4;
  localparam gpp_pkg::gpp_idx_t IDX_SK = 4'h5;
  localparam gpp_pkg::gpp_idx_t IDX_A0 = 4'h6;
  localparam gpp_pkg::gpp_idx_t IDX_A1 = 4'h7;
  localparam gpp_pkg::gpp_idx_t IDX_A2 = 4'h8;
  localparam gpp_pkg::gpp_idx_t IDX_NONE = 4'hF;

  // Maps an SFR address to a slot; unmapped addresses give IDX_NONE.
  function automatic gpp_pkg::gpp_idx_t addr_to_idx(input logic [7:0] a);
    unique case (a)
      `GPP_ADDR_PORT_ONE_DATA: addr_to_idx = IDX_P1;
      `GPP_ADDR_PORT_TWO_DATA: addr_to_idx = IDX_P2;
      `GPP_ADDR_PORT_ZERO_MDOUT: addr_to_idx = IDX_M0;
      `GPP_ADDR_PORT_ONE_MDOUT: addr_to_idx = IDX_M1;
      `GPP_ADDR_PORT_TWO_MDOUT: addr_to_idx = IDX_M2;
      `GPP_ADDR_PORT_ZERO_SKIP: addr_to_idx = IDX_SK;
      `GPP_ADDR_PORT_ZERO_MDIN: addr_to_idx = IDX_A0;
      `GPP_ADDR_PORT_ONE_MDIN: addr_to_idx = IDX_A1;
      `GPP_ADDR_PORT_TWO_MDIN: addr_to_idx = IDX_A2;
      default: addr_to_idx = IDX_NONE;
    endcase
  endfunction

  // Pin drive for one port: returns {oe, out}. An input-mode bit of zero marks an
  // analog pin, whose driver stays off whatever its latch and mode bits say.
  function automatic logic [15:0] pin_drive(input logic [7:0] latch,
                                            input logic [7:0] mode,
                                            input logic [7:0] digital,
                                            input logic en);
    logic [7:0] oe;
    logic [7:0] val;
    oe = 8'h00;
    // The output always follows the latch; only the pin's oe bit decides whether it reaches
    // the pin, so the latch stays visible on the port even while the drivers are off.
    val = latch;
    for (int i = 0; i < 8; i++) begin
      if (en && digital[i]) begin
        // A zero always pulls low; a one drives only in push-pull mode.
        oe[i] = !latch[i] || mode[i];
      end
    end
    pin_drive = {oe, val};
  endfunction

  // Readback: analog pins (input-mode bit zero) read zero, others the filtered level.
  function automatic logic [7:0] pin_read(input logic [7:0] lvl, input logic [7:0] digital);
    pin_read = lvl & digital;
  endfunction

  gpp_pkg::gpp_byte_t regs [`GPP_NUM_REGS];
  gpp_pkg::gpp_byte_t store_rdata;
  gpp_pkg::gpp_idx_t acc_idx;
  logic wr_hit;

  // Three-stage synchronisers for the asynchronous pins.
  logic [7:0] p1_s1_q, p1_s2_q, p1_s3_q, p1_lvl_q;
  logic [7:0] p2_s1_q, p2_s2_q, p2_s3_q, p2_lvl_q;
  logic [7:0] p1_lvl_d, p2_lvl_d;

  // Read path state.
  logic rd_pend_q, rd_pend_d;
  logic rmw_pend_q, rmw_pend_d;
  gpp_pkg::gpp_idx_t rd_idx_q, rd_idx_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;

  // Pin output state.
  logic [7:0] p1_out_q, p1_oe_q, p2_out_q, p2_oe_q;
  logic [7:0] p1_out_d, p1_oe_d, p2_out_d, p2_oe_d;
  logic [7:0] skip_q, a0_q, m0_q;

  assign acc_idx = addr_to_idx(sfr_addr);
  assign wr_hit = sfr_wr && (acc_idx != IDX_NONE);

  // Writes land in the store and hold until the next write.
  gpp_regfile u_store (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .wr_en(wr_hit),
    .wr_idx(acc_idx),
    .wr_data(sfr_wdata),
    .rd_idx(acc_idx),
    .rd_data(store_rdata),
    .regs_flat(regs)
  );

  // A pin level counts as changed once stages two and three agree.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      p1_lvl_d[i] = (p1_s2_q[i] == p1_s3_q[i]) ? p1_s3_q[i] : p1_lvl_q[i];
      p2_lvl_d[i] = (p2_s2_q[i] == p2_s3_q[i]) ? p2_s3_q[i] : p2_lvl_q[i];
    end
  end

  // Read sequencing: the store answers one cycle later, so the address is held.
  always_comb begin
    rd_pend_d = sfr_rd && (acc_idx != IDX_NONE);
    rmw_pend_d = sfr_rmw;
    rd_idx_d = acc_idx;
    rvalid_d = rd_pend_q || (sfr_rd && acc_idx == IDX_NONE && !rd_pend_q);
    rdata_d = 8'h00;
    if (rd_pend_q) begin
      if (rmw_pend_q) begin
        rdata_d = store_rdata;
      end else if (rd_idx_q == IDX_P1) begin
        rdata_d = pin_read(p1_lvl_q, regs[IDX_A1]);
      end else if (rd_idx_q == IDX_P2) begin
        rdata_d = pin_read(p2_lvl_q, regs[IDX_A2]);
      end else begin
        rdata_d = store_rdata;
      end
    end
  end

  // Pin drive from latch, mode and input-mode bits, gated by the crossbar enable.
  // The enable comes from logic on this clock, so it needs no synchroniser stages.
  always_comb begin
    {p1_oe_d, p1_out_d} = pin_drive(regs[IDX_P1], regs[IDX_M1], regs[IDX_A1],
                                    crossbar_global_enable);
    {p2_oe_d, p2_out_d} = pin_drive(regs[IDX_P2], regs[IDX_M2], regs[IDX_A2],
                                    crossbar_global_enable);
  end

  // All registers of the top level; outputs come straight from these.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      p1_s1_q <= 8'h00;
      p1_s2_q <= 8'h00;
      p1_s3_q <= 8'h00;
      p1_lvl_q <= 8'h00;
      p2_s1_q <= 8'h00;
      p2_s2_q <= 8'h00;
      p2_s3_q <= 8'h00;
      p2_lvl_q <= 8'h00;
      rd_pend_q <= 1'b0;
      rmw_pend_q <= 1'b0;
      rd_idx_q <= IDX_NONE;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      p1_out_q <= 8'h00;
      p1_oe_q <= 8'h00;
      p2_out_q <= 8'h00;
      p2_oe_q <= 8'h00;
      skip_q <= `GPP_RST_SKIP;
      a0_q <= `GPP_RST_MDIN;
      m0_q <= `GPP_RST_MDOUT;
    end else begin
      p1_s1_q <= port_one_pin_in;
      p1_s2_q <= p1_s1_q;
      p1_s3_q <= p1_s2_q;
      p1_lvl_q <= p1_lvl_d;
      p2_s1_q <= port_two_pin_in;
      p2_s2_q <= p2_s1_q;
      p2_s3_q <= p2_s2_q;
      p2_lvl_q <= p2_lvl_d;
      rd_pend_q <= rd_pend_d;
      rmw_pend_q <= rmw_pend_d;
      rd_idx_q <= rd_idx_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      p1_out_q <= p1_out_d;
      p1_oe_q <= p1_oe_d;
      p2_out_q <= p2_out_d;
      p2_oe_q <= p2_oe_d;
      skip_q <= regs[IDX_SK];
      a0_q <= regs[IDX_A0];
      m0_q <= regs[IDX_M0];
    end
  end

  assign sfr_rdata = rdata_q;
  assign sfr_rvalid = rvalid_q;
  assign port_one_pin_out = p1_out_q;
  assign port_one_pin_oe = p1_oe_q;
  assign port_two_pin_out = p2_out_q;
  assign port_two_pin_oe = p2_oe_q;
  assign port_zero_crossbar_bypass = skip_q;
  assign port_zero_analog_select = a0_q;
  assign port_zero_output_drive_mode = m0_q;
endmodule

// File: testbench/gpp_port_properties.sv
// Concurrent checks on the port block's register and pin ports.
`timescale 1ns/100ps
`include "gpp_cfg.svh"
module gpp_port_properties (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rvalid,
  input wire logic crossbar_global_enable,
  input wire logic [7:0] port_one_pin_out,
  input wire logic [7:0] port_one_pin_oe,
  input wire logic [7:0] port_two_pin_oe,
  input wire logic [7:0] port_zero_crossbar_bypass,
  input wire logic [7:0] port_zero_output_drive_mode
);
  // All checks share the core clock and its reset.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // A read or write request taken at one edge.
  sequence rd_req(a);
    sfr_rd && sfr_addr == a;
  endsequence
  sequence wr_req(a);
    sfr_wr && sfr_addr == a;
  endsequence
  xbar_off_idle_a: assert property (!crossbar_global_enable |-> ##1
    (port_one_pin_oe == 8'h00 && port_two_pin_oe == 8'h00)) else $error("pin driven, crossbar off");
  rd_answer_a: assert property (rd_req(`GPP_ADDR_PORT_ONE_DATA) |-> ##2 sfr_rvalid)
    else $error("read answer late");
  unmapped_read_a: assert property (rd_req(8'h55) |-> ##1 (sfr_rvalid && sfr_rdata == 8'h00))
    else $error("unmapped read not zero");
  rdata_idle_a: assert property (!sfr_rvalid |-> sfr_rdata == 8'h00)
    else $error("read data left standing");
  skip_copy_a: assert property (wr_req(`GPP_ADDR_PORT_ZERO_SKIP) |-> ##2
    port_zero_crossbar_bypass == $past(sfr_wdata, 2)) else $error("bypass copy wrong");
  mode_copy_a: assert property (wr_req(`GPP_ADDR_PORT_ZERO_MDOUT) |-> ##2
    port_zero_output_drive_mode == $past(sfr_wdata, 2)) else $error("mode copy wrong");
  skip_hold_a: assert property (!(sfr_wr && sfr_addr == `GPP_ADDR_PORT_ZERO_SKIP) |-> ##2
    $stable(port_zero_crossbar_bypass)) else $error("bypass changed unwritten");
  // The bench never writes port one around a latch read, so the pins' latch copy is settled.
  rmw_latch_a: assert property ((rd_req(`GPP_ADDR_PORT_ONE_DATA) ##0 sfr_rmw) |-> ##2
    sfr_rdata == port_one_pin_out) else $error("latch read wrong");
endmodule
bind gpp_port_top gpp_port_properties gpp_port_properties_i (.core_clk(core_clk),
  .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
  .crossbar_global_enable(crossbar_global_enable), .port_one_pin_out(port_one_pin_out),
  .port_one_pin_oe(port_one_pin_oe), .port_two_pin_oe(port_two_pin_oe),
  .port_zero_crossbar_bypass(port_zero_crossbar_bypass),
  .port_zero_output_drive_mode(port_zero_output_drive_mode));

// File: testbench/gpp_pin_world.sv
// Behavioural model of the circuitry on one eight-pin port.
`timescale 1ns/100ps
module gpp_pin_world (
  input wire logic core_clk,
  input wire logic [7:0] drv_out,
  input wire logic [7:0] drv_oe,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_level
);
  // Undriven pins have no pull-up, so they flip each cycle instead of holding a value.
  logic [7:0] float_q = 8'h5A;
  always @(posedge core_clk) begin
    float_q <= ~float_q;
  end
  // The block wins where it drives, then the outside source, else the floating level.
  always_comb begin
    pin_level = (drv_oe & drv_out) | (~drv_oe & ext_en & ext_val) | (~drv_oe & ~ext_en & float_q);
  end
endmodule

// File: testbench/tb.sv
// Self-checking bench for the port latches, readback and mode registers.
`timescale 1ns/100ps
`include "gpp_cfg.svh"
module tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, rdata, bypass, an0, md0, got, l, m, e, a, o;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rmw = 1'b0, xbar = 1'b0, rvalid;
  logic [1:0][7:0] pin_in, pin_out, pin_oe;
  logic [1:0][7:0] ext_en = 16'h0000, ext_val = 16'h0000;
  int error_cnt = 0, checks_done = 0;
  int unsigned seed = 77;
  localparam logic [7:0] DAT [2] = '{`GPP_ADDR_PORT_ONE_DATA, `GPP_ADDR_PORT_TWO_DATA};
  localparam logic [7:0] MDO [2] = '{`GPP_ADDR_PORT_ONE_MDOUT, `GPP_ADDR_PORT_TWO_MDOUT};
  localparam logic [7:0] MDI [2] = '{`GPP_ADDR_PORT_ONE_MDIN, `GPP_ADDR_PORT_TWO_MDIN};
  gpp_port_top gpp_port_top_i (.core_clk(core_clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw),
    .sfr_rdata(rdata), .sfr_rvalid(rvalid), .crossbar_global_enable(xbar),
    .port_one_pin_in(pin_in[0]), .port_two_pin_in(pin_in[1]), .port_one_pin_out(pin_out[0]),
    .port_one_pin_oe(pin_oe[0]), .port_two_pin_out(pin_out[1]), .port_two_pin_oe(pin_oe[1]),
    .port_zero_crossbar_bypass(bypass), .port_zero_analog_select(an0),
    .port_zero_output_drive_mode(md0));
  gpp_pin_world gpp_pin_world_i [1:0] (.core_clk(core_clk), .drv_out(pin_out), .drv_oe(pin_oe),
    .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_in));
  // Free-running 100 ns clock.
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  // Xorshift source, repeatable from its fixed start.
  function logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Drivers are on unless the pin is analog (input-mode bit zero), or open-drain and high.
  function logic [7:0] exp_oe(input logic [7:0] l, input logic [7:0] m, input logic [7:0] a);
    return (~l | m) & a;
  endfunction
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    #1 {sfr_addr, sfr_wdata, sfr_wr} = {ad, d, 1'b1};
    @(posedge core_clk);
    #1 sfr_wr = 1'b0;
  endtask
  // Read data is captured in the single cycle that the valid pulse stands.
  task automatic rd(input logic [7:0] ad, input logic mw, output logic [7:0] d);
    d = 8'hxx;
    @(posedge core_clk);
    #1 {sfr_addr, sfr_rd, sfr_rmw} = {ad, 1'b1, mw};
    @(posedge core_clk);
    #1 {sfr_rd, sfr_rmw} = 2'b00;
    repeat (3) begin
      if (rvalid === 1'b1) d = rdata;
      @(posedge core_clk);
      #1;
    end
  endtask
  task complete_run();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Guard against a hang, far beyond the few hundred cycles the run needs.
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    #1 reset_n = 1'b1;
    rd(`GPP_ADDR_PORT_ZERO_MDOUT, 1'b0, got); chk("mode reset", got, 8'h00);
    rd(`GPP_ADDR_PORT_ZERO_SKIP, 1'b0, got); chk("skip reset", got, 8'h00);
    rd(DAT[0], 1'b1, got); chk("latch reset", got, 8'hFF);
    // Port two pins float here, so every pin is made analog before the read.
    wr(MDI[1], 8'h00);
    rd(DAT[1], 1'b0, got); chk("analog reset read", got, 8'h00);
    wr(8'h55, rnd());
    rd(8'h55, 1'b0, got); chk("unmapped", got, 8'h00);
    xbar = 1'b1;
    // Random latch, mode and input-mode mixes per port; three passes all digital first.
    for (int i = 0; i < 12; i++) begin
      {l, m, e, a} = {rnd(), rnd(), rnd(), (i % 6 < 3) ? 8'hFF : rnd()};
      if (i % 6 == 0) l = 8'h00;
      if (i % 6 == 1) {l, m} = 16'hFF00;
      wr(DAT[i / 6], l);
      wr(MDO[i / 6], m);
      wr(MDI[i / 6], a);
      o = exp_oe(l, m, a);
      {ext_en[i / 6], ext_val[i / 6]} = {~o, e};
      repeat (8) @(posedge core_clk);
      #1 chk("pin enable", pin_oe[i / 6], o);
      chk("pin level", pin_out[i / 6] & o, l & o);
      rd(DAT[i / 6], 1'b0, got); chk("pin read", got, ((o & l) | (~o & e)) & a);
      rd(DAT[i / 6], 1'b1, got); chk("latch read", got, l);
    end
    xbar = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 chk("pins released", pin_oe[0] | pin_oe[1], 8'h00);
    {l, m, a} = {rnd(), rnd(), rnd()};
    wr(`GPP_ADDR_PORT_ZERO_SKIP, l);
    wr(`GPP_ADDR_PORT_ZERO_MDOUT, m);
    wr(`GPP_ADDR_PORT_ZERO_MDIN, a);
    @(posedge core_clk);
    #1 chk("bypass copy", bypass, l);
    chk("mode copy", md0, m);
    chk("analog copy", an0, a);
    rd(`GPP_ADDR_PORT_ZERO_SKIP, 1'b0, got); chk("skip read", got, l);
    reset_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 reset_n = 1'b1;
    chk("bypass after reset", bypass, 8'h00);
    chk("analog after reset", an0, 8'hFF);
    complete_run();
  end
endmodule
